// ==== core/dcss_regs.svh ====
// constants for the dual-channel safety stop block
`ifndef DCSS_REGS_SVH
`define DCSS_REGS_SVH
`define DCSS_CLK_HZ         10000000
`define DCSS_FILT_MS        2
`define DCSS_FILT_CYC       ((`DCSS_CLK_HZ / 1000) * `DCSS_FILT_MS)
`define DCSS_CNT_W          15
`define DCSS_SEL_W          8
`define DCSS_CODE_RUN       8'h00
`define DCSS_CODE_FDET      8'h01
`define DCSS_CODE_STOP      8'h50
`define DCSS_CODE_HEALTH    8'h51
`define DCSS_CODE_STOP_N    8'hB4
`define DCSS_CODE_HEALTH_N  8'hB5
`define DCSS_SEL0_RST       8'h00
`define DCSS_SEL1_RST       8'h01
`define DCSS_SEL2_RST       8'h00
`define DCSS_A_SEL0         2'h0
`define DCSS_A_SEL1         2'h1
`define DCSS_A_SEL2         2'h2
`define DCSS_A_STAT         2'h3
`define DCSS_FAULT_NONE     3'h0
`define DCSS_FAULT_SAF      3'h1
`define DCSS_FAULT_B        3'h2
`define DCSS_FAULT_C        3'h3
`define DCSS_FAULT_CPU      3'h4
`define DCSS_FAULT_STOP     3'h5
`endif

// ==== core/dcss_pkg.sv ====
// types for the dual-channel safety stop block
package dcss_pkg;
  typedef enum logic [1:0] {
    DCSS_FLT_SAF,
    DCSS_FLT_B,
    DCSS_FLT_C,
    DCSS_FLT_CPU
  } dcss_fault_t;
endpackage

// ==== core/dcss_chan_if.sv ====
// filtered channel levels shared between filter and top
`timescale 1ns/1ps
interface dcss_chan_if;
  logic shorted;
  logic changed;
  modport filt (output shorted, output changed);
  modport core (input shorted, input changed);
endinterface

// ==== core/dcss_filter.sv ====
// three-flop sync and 2 ms hold filter for one safety channel
`timescale 1ns/1ps
`include "dcss_regs.svh"
module dcss_filter (
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_sys_rst,
  // raw pin, high when channel is shorted to common
  input  wire logic  i_raw,
  // filtered result
  dcss_chan_if.filt  chan
);
  logic [2:0]            sync_r;
  logic [`DCSS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                  lvl_r, lvl_nxt;
  logic                  chg_r, chg_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    lvl_nxt = lvl_r;
    chg_nxt = 1'b0;
    if (sync_r[2] != sync_r[1] || sync_r[1] == lvl_r) begin
      cnt_nxt = '0;
    end else if (cnt_r == `DCSS_CNT_W'(`DCSS_FILT_CYC - 1)) begin
      cnt_nxt = '0;
      lvl_nxt = sync_r[1];
      chg_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + `DCSS_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync_r <= 3'h0;
      cnt_r  <= '0;
      lvl_r  <= 1'b0;
      chg_r  <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], i_raw};
      cnt_r  <= cnt_nxt;
      lvl_r  <= lvl_nxt;
      chg_r  <= chg_nxt;
    end
  end

  assign chan.shorted = lvl_r;
  assign chan.changed = chg_r;
endmodule

// ==== core/dcss_term.sv ====
// one open-collector output terminal with function select
`timescale 1ns/1ps
`include "dcss_regs.svh"
module dcss_term (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  // selector code and function sources
  input  wire logic [`DCSS_SEL_W-1:0] i_sel,
  input  wire logic                   i_stop,
  input  wire logic                   i_health,
  input  wire logic                   i_running,
  input  wire logic                   i_fdet,
  // transistor conducts when high
  output logic                        o_on
);
  logic on_r, on_nxt;

  always_comb begin
    case (i_sel)
      `DCSS_CODE_STOP:     on_nxt = i_stop;
      `DCSS_CODE_STOP_N:   on_nxt = ~i_stop;
      `DCSS_CODE_HEALTH:   on_nxt = i_health;
      `DCSS_CODE_HEALTH_N: on_nxt = ~i_health;
      `DCSS_CODE_RUN:      on_nxt = i_running;
      `DCSS_CODE_FDET:     on_nxt = i_fdet;
      default:             on_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      on_r <= 1'b0;
    end else begin
      on_r <= on_nxt;
    end
  end

  assign o_on = on_r;
endmodule

// ==== core/dcss_top.sv ====
// dual-channel safety stop: filtering, enable, status terminals, registers
`timescale 1ns/1ps
`include "dcss_regs.svh"
module dcss_top (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  // safety channel pins, high when shorted to safety_input_common
  input  wire logic                   i_safety_channel_one,
  input  wire logic                   i_safety_channel_two,
  // internal failure detectors, one per fault kind, same clock
  input  wire logic [3:0]             i_fail_det,
  // other terminal functions, same clock
  input  wire logic                   i_running,
  input  wire logic                   i_fdet,
  // register port
  input  wire logic [1:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  // drive and status
  output logic                        o_drive_enable,
  output logic                        o_stop_status,
  output logic                        o_health_status,
  output logic      [2:0]             o_panel_code,
  // open-collector terminals: run, freq_detect_terminal, run
  output logic      [2:0]             o_term_on,
  // interrupt
  output logic                        o_irq
);
  dcss_chan_if ch1 ();
  dcss_chan_if ch2 ();

  dcss_filter u_f1 (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_raw     (i_safety_channel_one),
    .chan      (ch1)
  );
  dcss_filter u_f2 (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_raw     (i_safety_channel_two),
    .chan      (ch2)
  );

  // selectors
  logic [`DCSS_SEL_W-1:0] sel_r [3];
  logic [`DCSS_SEL_W-1:0] sel_nxt [3];
  // latched failure and first fault kind
  logic                   fail_r, fail_nxt;
  logic [2:0]             fcode_r, fcode_nxt;
  // status outputs
  logic                   en_r, en_nxt;
  logic                   stop_r, stop_nxt;
  logic                   health_r, health_nxt;
  logic [2:0]             panel_r, panel_nxt;
  // interrupt status and mask: b0 ch1 change, b1 ch2 change, b2 fault, b3 stop entered
  logic [3:0]             ist_r, ist_nxt;
  logic [3:0]             imask_r, imask_nxt;
  logic [7:0]             rdata_r, rdata_nxt;
  logic [3:0]             ev;
  logic                   fail_now;

  function automatic logic [2:0] fault_code(input logic [3:0] det);
    if (det[dcss_pkg::DCSS_FLT_SAF])      fault_code = `DCSS_FAULT_SAF;
    else if (det[dcss_pkg::DCSS_FLT_B])   fault_code = `DCSS_FAULT_B;
    else if (det[dcss_pkg::DCSS_FLT_C])   fault_code = `DCSS_FAULT_C;
    else                                  fault_code = `DCSS_FAULT_CPU;
  endfunction

  assign fail_now = fail_r | (|i_fail_det);

  always_comb begin
    fail_nxt  = fail_r;
    fcode_nxt = fcode_r;
    if (!fail_r && (|i_fail_det)) begin
      fail_nxt  = 1'b1;
      fcode_nxt = fault_code(i_fail_det);
    end
    en_nxt     = ch1.shorted & ch2.shorted & ~fail_now;
    stop_nxt   = ~en_nxt & ~fail_now;
    health_nxt = ~fail_now;
    if (fail_nxt) begin
      panel_nxt = fcode_nxt;
    end else if (!ch1.shorted && !ch2.shorted) begin
      panel_nxt = `DCSS_FAULT_STOP;
    end else begin
      panel_nxt = `DCSS_FAULT_NONE;
    end
  end

  assign ev = {stop_nxt & ~stop_r, fail_nxt & ~fail_r, ch2.changed, ch1.changed};

  always_comb begin
    sel_nxt   = sel_r;
    imask_nxt = imask_r;
    ist_nxt   = ist_r;
    rdata_nxt = 8'h00;
    if (i_wr) begin
      case (i_addr)
        `DCSS_A_SEL0: sel_nxt[0] = i_wdata;
        `DCSS_A_SEL1: sel_nxt[1] = i_wdata;
        `DCSS_A_SEL2: sel_nxt[2] = i_wdata;
        `DCSS_A_STAT: begin
          ist_nxt   = ist_r & ~i_wdata[3:0];
          imask_nxt = i_wdata[7:4];
        end
        default: ;
      endcase
    end
    ist_nxt = ist_nxt | ev;
    if (i_rd) begin
      case (i_addr)
        `DCSS_A_SEL0: rdata_nxt = sel_r[0];
        `DCSS_A_SEL1: rdata_nxt = sel_r[1];
        `DCSS_A_SEL2: rdata_nxt = sel_r[2];
        `DCSS_A_STAT: rdata_nxt = {imask_r, ist_r};
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sel_r[0] <= `DCSS_SEL0_RST;
      sel_r[1] <= `DCSS_SEL1_RST;
      sel_r[2] <= `DCSS_SEL2_RST;
      fail_r   <= 1'b0;
      fcode_r  <= `DCSS_FAULT_NONE;
      en_r     <= 1'b0;
      stop_r   <= 1'b0;
      health_r <= 1'b0;
      panel_r  <= `DCSS_FAULT_NONE;
      ist_r    <= 4'h0;
      imask_r  <= 4'h0;
      rdata_r  <= 8'h00;
    end else begin
      sel_r    <= sel_nxt;
      fail_r   <= fail_nxt;
      fcode_r  <= fcode_nxt;
      en_r     <= en_nxt;
      stop_r   <= stop_nxt;
      health_r <= health_nxt;
      panel_r  <= panel_nxt;
      ist_r    <= ist_nxt;
      imask_r  <= imask_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  genvar t;
  generate
    for (t = 0; t < 3; t++) begin : g_term
      dcss_term u_term (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_sel     (sel_r[t]),
        .i_stop    (stop_r),
        .i_health  (health_r),
        .i_running (i_running),
        .i_fdet    (i_fdet),
        .o_on      (o_term_on[t])
      );
    end
  endgenerate

  assign o_drive_enable  = en_r;
  assign o_stop_status   = stop_r;
  assign o_health_status = health_r;
  assign o_panel_code    = panel_r;
  assign o_rdata         = rdata_r;
  assign o_irq           = |(ist_r & imask_r);
endmodule

// ==== bench/dcss_relay_model.sv ====
// safety relay model: channel contacts with restart feedback
`timescale 1ns/1ps
module dcss_relay_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_feedback,
  input  wire logic [1:0] i_close,
  output logic      [1:0] o_ch
);
  initial o_ch = 2'h0;
  // contacts close only while the health feedback is on
  always @(posedge i_clk_sys) begin
    o_ch <= i_close & {2{i_feedback}};
  end
endmodule

// ==== bench/dcss_assertions.sv ====
// assertions on the safety stop top ports
`timescale 1ns/1ps
`include "dcss_regs.svh"
module dcss_assertions (
  input wire logic       i_clk_sys,
  input wire logic       i_sys_rst,
  input wire logic       i_safety_channel_one,
  input wire logic       i_safety_channel_two,
  input wire logic [3:0] i_fail_det,
  input wire logic       o_drive_enable,
  input wire logic       o_stop_status,
  input wire logic       o_health_status,
  input wire logic [2:0] o_panel_code
);
  logic [15:0] shut_r;
  logic [15:0] open_r;
  wire         both_w = i_safety_channel_one & i_safety_channel_two;
  always_ff @(posedge i_clk_sys) begin
    shut_r <= (i_sys_rst | ~both_w) ? 16'h0000 : shut_r + {15'h0000, shut_r != 16'hFFFF};
    open_r <= (i_sys_rst | both_w) ? 16'h0000 : open_r + {15'h0000, open_r != 16'hFFFF};
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_failed;
    !o_health_status && !o_drive_enable && !o_stop_status;
  endsequence
  a_enable_healthy: assert property (o_drive_enable |-> o_health_status)
    else $error("enable without health");
  a_stop_meaning: assert property (o_stop_status |-> o_health_status && !o_drive_enable)
    else $error("stop status wrong");
  a_fail_shutoff: assert property (|i_fail_det |-> ##[1:3] s_failed)
    else $error("failure not acted on");
  a_fail_latched: assert property (!o_health_status && !$past(i_sys_rst) |=> s_failed)
    else $error("failure not held");
  a_filter_hold: assert property ($rose(o_drive_enable) |-> shut_r >= `DCSS_FILT_CYC)
    else $error("enable before hold time");
  a_open_stops: assert property (open_r > `DCSS_FILT_CYC + 10 |-> !o_drive_enable)
    else $error("open channel left drive on");
  a_panel_stop: assert property (o_panel_code == `DCSS_FAULT_STOP |-> ##[0:1] o_stop_status)
    else $error("stop shown without stop");
  a_panel_fault: assert property (o_panel_code inside {[3'h1:3'h4]} |-> ##[0:1] !o_health_status)
    else $error("fault shown while healthy");
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the safety stop top
`timescale 1ns/1ps
module tb;
  logic       i_clk_sys, i_sys_rst, i_running, i_fdet, i_wr, i_rd;
  logic       i_safety_channel_one, i_safety_channel_two;
  logic       o_drive_enable, o_stop_status, o_health_status, o_irq;
  logic [1:0] i_addr, close_r;
  logic [2:0] o_panel_code, o_term_on;
  logic [3:0] i_fail_det;
  logic [7:0] i_wdata, o_rdata, rd_v;
  logic [8:0] rows [7] = '{9'h100, 9'h001, 9'h150, 9'h0B4, 9'h151, 9'h0B5, 9'h07F};
  int         errors, total_checks, n;
  wire  [7:0] st = {o_irq, o_drive_enable, o_stop_status, o_health_status, 1'b0, o_panel_code};
  dcss_top dut (.*);
  dcss_relay_model relay (.i_clk_sys(i_clk_sys), .i_feedback(o_health_status),
    .i_close(close_r), .o_ch({i_safety_channel_two, i_safety_channel_one}));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk_sys);
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic see(input logic [7:0] e, input logic [2:0] t);
    @(negedge i_clk_sys);
    chk(st, e);
    chk({5'h00, o_term_on}, {5'h00, t});
    cyc(1);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    cyc(1);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge i_clk_sys);
    {i_addr, i_rd} <= {a, 1'b1};
    cyc(1);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rd_v = o_rdata;
    cyc(1);
  endtask
  task automatic wait_en(input logic v);
    n = 0;
    while (o_drive_enable !== v) begin
      cyc(1);
      n++;
      if (n > 20100) begin
        errors++;
        report_and_stop();
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {i_sys_rst, i_running, i_fdet, i_wr, i_rd} = 5'b11000;
    {i_addr, i_wdata, i_fail_det, close_r} = '0;
    cyc(5);
    see(8'h00, 3'h0);
    i_sys_rst <= 1'b0;
    cyc(2);
    see(8'h35, 3'h5);
    for (int k = 0; k < 3; k++) begin
      rd(2'(k));
      chk(rd_v, (k == 1) ? 8'h01 : 8'h00);
      foreach (rows[r]) begin
        wr(2'(k), rows[r][7:0]);
        cyc(3);
        chk({7'h00, o_term_on[k]}, {7'h00, rows[r][8]});
        rd(2'(k));
        chk(rd_v, rows[r][7:0]);
      end
    end
    wr(2'h0, 8'h51);
    wr(2'h1, 8'h50);
    wr(2'h2, 8'hB4);
    wr(2'h3, 8'h1F);
    close_r <= 2'h3;
    cyc(1000);
    close_r <= 2'h0;
    cyc(20);
    see(8'h35, 3'h3);
    close_r <= 2'h3;
    wait_en(1'b1);
    chk({7'h00, n > 19999}, 8'h01);
    cyc(3);
    see(8'hD0, 3'h5);
    rd(2'h3);
    chk({6'h00, rd_v[1:0]}, 8'h03);
    wr(2'h3, 8'h13);
    see(8'h50, 3'h5);
    close_r <= 2'h1;
    wait_en(1'b0);
    cyc(3);
    see(8'h30, 3'h3);
    for (int i = 0; i < 4; i++) begin
      i_fail_det <= 4'(1 << i);
      cyc(1);
      i_fail_det <= 4'h0;
      cyc(3);
      see(8'(i + 1), (i == 0) ? 3'h4 : 3'h5);
      i_sys_rst <= 1'b1;
      cyc(6);
      i_sys_rst <= 1'b0;
      cyc(2);
      see(8'h35, 3'h5);
    end
    report_and_stop();
  end
endmodule
bind dcss_top dcss_assertions chk_u (.*);
